// File: cdctl_top.sv
// Control logic of a four-channel clock distribution device.
// Assumes an Avalon-MM master on CLK_SYS and a temperature code from an
// asynchronous sensor converter; CLK_SYS stands in for the input clock.
`timescale 1ns/100ps

// Behaviour
// R1: Power-up reset restores every register and clears all counters and dividers.
// R2: Default state: SYSREF off, dividers bypassed, plain four-output buffer.
// R3: Host waits the power-on interval before programming other registers.
// R4: Writing reset one does a full reset; any other register write clears it; a status register write leaves it set.
// R5: Writing reset zero also clears the reset bit.
// R6: Host should issue a software reset after the power-on reset.
// R7: Software reset finishes before the next register write is accepted.
// R8: A readable temperature code; degrees equal 0.65 times code minus 351.
// R9: All four main outputs share one frequency.
// R10: Path enable zero powers down channel path and buffer regardless of others.
// R11: Buffer enable gates only the buffer; path and SYSREF stay up.
// R12: Each enabled buffer uses its own power level, 0 minimum to 7 maximum.
// R13: Source select 0 is buffer, 1 divider, 2 multiplier.
// R14: Divider codes 1 to 7 divide by code plus one; code 0 reserved.
// R15: Even divides 50% duty; 3, 5, 7 give 33, 40, 43 percent.
// R16: Host toggles divider reset one then zero after input frequency changes.
// R17: Logic-rate clock: pre-divide 1, 2 or 4 then divide 1 to 1023.
// R18: SYSREF generator: pre-divide 1, 2 or 4 then divide 2 to 4095.
// R19: Delay divider supports divide by 2, 4, 8 and 16.
// R20: Multiplier mode supports factors x1 to x4; x1 is filter mode.
// R21: Requests are taken only while the host selects the device.
// R22: Read data is driven only in the answer; held low otherwise.
// R23: Divider reset holds the main divider cleared; restarts cleanly after.
module cdctl_top #(
  parameter int POR_CYCLES = cdctl_pkg::POR_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Avalon-MM slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Sensor
  input wire logic [cdctl_pkg::TEMP_W-1:0] TEMP_CODE,
  // Channel power
  output cdctl_pkg::cdctl_chan_pwr_t CHAN_PWR,
  // Clocks
  output logic [cdctl_pkg::NCH-1:0] MAIN_CLK,
  output logic [cdctl_pkg::NCH-1:0] SYSREF_OUT,
  output logic LOGIC_RATE_CLOCK,
  output logic LOGIC_SYSREF_OUTPUT,
  output logic DELAY_CLK,
  // Multiplier and reset status
  output logic [2:0] MULT_FACTOR,
  output logic RESET_BUSY
);
  import cdctl_pkg::*;

  localparam int CW = $clog2(POR_CYCLES + SRST_CYC + 1);

  typedef struct packed {
    cdctl_cfg_t cfg;
    logic [CW-1:0] rst_cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic [TEMP_W-1:0] tsync1;
    logic [TEMP_W-1:0] tsync2;
    logic [TEMP_W-1:0] tsync3;
    logic [TEMP_W-1:0] temp;
    logic byp;
    cdctl_chan_pwr_t chan;
    logic [NCH-1:0] main_clk;
    logic [NCH-1:0] sysref;
    logic lclk;
    logic lsref;
    logic dclk;
    logic [2:0] mult;
    logic busy;
  } cdctl_st_t;

  cdctl_st_t st;
  cdctl_st_t next_st;

  function automatic logic [2:0] pre_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: pre_ratio = 3'h1;
      2'h1: pre_ratio = 3'h2;
      default: pre_ratio = 3'h4;
    endcase
  endfunction : pre_ratio

  // ****************************************************************
  // Dividers
  // ****************************************************************
  logic busy;
  logic main_clr;
  logic [3:0] main_ratio;
  logic main_lvl;
  logic lgc_clr;
  logic lp_pulse;
  logic ld_lvl;
  logic [9:0] ld_ratio;
  logic sr_clr;
  logic sp_pulse;
  logic sd_lvl;
  logic [11:0] sd_ratio;
  logic dly_lvl;

  assign busy = st.rst_cnt != '0;
  // Counter stays cleared while the divider reset bit is set.
  assign main_clr = busy | st.cfg.ctrl.div_rst | (st.cfg.ctrl.src != SRC_DIV); // R23
  assign main_ratio = (st.cfg.ctrl.div_code == 3'h0) ? 4'h1 :
                      ({1'b0, st.cfg.ctrl.div_code} + 4'h1); // R14
  assign lgc_clr = busy | ~st.cfg.lgc.en;
  // A zero logic divide acts as one and a SYSREF divide below two acts as two.
  assign ld_ratio = (st.cfg.lgc.div == 10'h000) ? 10'h001 : st.cfg.lgc.div; // R17
  assign sr_clr = busy | ~st.cfg.sref.en;
  assign sd_ratio = (st.cfg.sref.div < 12'h002) ? 12'h002 : st.cfg.sref.div; // R18

  cdctl_div #(.W(4)) u_main (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(main_clr),
    .tick(1'b1),
    .ratio(main_ratio),
    .pulse(),
    .lvl(main_lvl) // R15
  );

  cdctl_div #(.W(3)) u_lpre (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(lgc_clr),
    .tick(1'b1),
    .ratio(pre_ratio(st.cfg.lgc.pre)),
    .pulse(lp_pulse),
    .lvl()
  );

  cdctl_div #(.W(10)) u_ldiv (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(lgc_clr),
    .tick(lp_pulse),
    .ratio(ld_ratio),
    .pulse(),
    .lvl(ld_lvl) // R17
  );

  cdctl_div #(.W(3)) u_spre (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(sr_clr),
    .tick(1'b1),
    .ratio(pre_ratio(st.cfg.sref.pre)),
    .pulse(sp_pulse),
    .lvl()
  );

  cdctl_div #(.W(12)) u_sdiv (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(sr_clr),
    .tick(sp_pulse),
    .ratio(sd_ratio),
    .pulse(),
    .lvl(sd_lvl) // R18
  );

  // The delay divider ignores the SYSREF enable; the delay block always needs it.
  cdctl_div #(.W(5)) u_dly (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .clr(busy),
    .tick(1'b1),
    .ratio(5'h02 << st.cfg.sref.dly_sel),
    .pulse(),
    .lvl(dly_lvl) // R19
  );

  // ****************************************************************
  // Register access and output state
  // ****************************************************************
  logic [31:0] rd_mux;
  cdctl_stat_t stat;

  always_comb begin
    stat = '0;
    stat.busy = busy;
    stat.temp = st.temp; // R8
  end

  // ****************************************************************
  // Register decode
  // ****************************************************************
  always_comb begin
    case (AVS_ADDRESS)
      OFF_CTRL: rd_mux = st.cfg.ctrl;
      OFF_CHAN: rd_mux = st.cfg.chan;
      OFF_LGC: rd_mux = st.cfg.lgc;
      OFF_SREF: rd_mux = st.cfg.sref;
      OFF_STAT: rd_mux = stat;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.tsync1 = TEMP_CODE;
    next_st.tsync2 = st.tsync1;
    next_st.tsync3 = st.tsync2;
    // Each code bit is synchronised on its own, so a code caught while
    // changing is only taken once two samples in a row agree.
    if (st.tsync2 == st.tsync3) begin
      next_st.temp = st.tsync2; // R8
    end
    // Buffer and multiplier modes cannot scale a logic clock; both show half rate.
    next_st.byp = ~st.byp;
    next_st.waitreq = 1'b1;
    // Read data stays zero outside the answer cycle.
    next_st.rdata = 32'h0000_0000; // R22
    if (busy) begin
      next_st.rst_cnt = st.rst_cnt - CW'(1);
    end
    // Nothing is accepted while a reset runs, so a reset always ends
    // before the following write lands.
    if (!busy && (AVS_READ || AVS_WRITE)) begin // R7 R3 R21
      if (st.waitreq) begin
        next_st.waitreq = 1'b0;
        if (AVS_READ) begin
          next_st.rdata = rd_mux; // R22
        end
      end else if (AVS_WRITE) begin
        case (AVS_ADDRESS)
          OFF_CTRL: begin
            if (AVS_WRITEDATA[0]) begin
              next_st.cfg = CFG_RST; // R4
              next_st.cfg.ctrl.srst = 1'b1; // R4
              next_st.rst_cnt = CW'(SRST_CYC); // R4
            end else begin
              next_st.cfg.ctrl = AVS_WRITEDATA; // R5
              next_st.cfg.ctrl.rsv = '0;
            end
          end
          OFF_CHAN: begin
            next_st.cfg.chan = AVS_WRITEDATA;
            next_st.cfg.chan.rsv = '0;
            next_st.cfg.ctrl.srst = 1'b0; // R4
          end
          OFF_LGC: begin
            next_st.cfg.lgc = AVS_WRITEDATA;
            next_st.cfg.lgc.rsv = '0;
            next_st.cfg.ctrl.srst = 1'b0; // R4
          end
          OFF_SREF: begin
            next_st.cfg.sref = AVS_WRITEDATA;
            next_st.cfg.sref.rsv = '0;
            next_st.cfg.ctrl.srst = 1'b0; // R4
          end
          default: begin
          end
        endcase
      end
    end

    for (int i = 0; i < NCH; i++) begin
      next_st.chan.path_up[i] = st.cfg.chan.path_en[i]; // R10
      next_st.chan.buf_up[i] = st.cfg.chan.path_en[i] & st.cfg.chan.buf_en[i]; // R10 R11
      next_st.chan.level[i] = next_st.chan.buf_up[i] ? st.cfg.chan.pwr[i] : 3'h0; // R12
      // One shared source feeds every channel.
      next_st.main_clk[i] = next_st.chan.buf_up[i] & ~busy &
                            ((st.cfg.ctrl.src == SRC_DIV) ? main_lvl : st.byp); // R9 R13
      next_st.sysref[i] = st.cfg.chan.path_en[i] & sd_lvl; // R11
    end
    next_st.lclk = st.cfg.lgc.en & ld_lvl;
    next_st.lsref = st.cfg.lgc.en & sd_lvl;
    next_st.dclk = dly_lvl;
    // The multiplier loop itself is analog; only its factor is exported.
    next_st.mult = (st.cfg.ctrl.src == SRC_MULT) ?
                   ({1'b0, st.cfg.ctrl.mult_code} + 3'h1) : 3'h1; // R20 R13
    next_st.busy = busy;
  end

  // Power-on reset loads defaults and runs the busy interval.
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
      st.cfg <= CFG_RST; // R1 R2
      st.rst_cnt <= CW'(POR_CYCLES); // R1 R3
      st.waitreq <= 1'b1;
      st.busy <= 1'b1;
      st.mult <= 3'h1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign AVS_READDATA = st.rdata;
  assign AVS_WAITREQUEST = st.waitreq;
  assign CHAN_PWR = st.chan;
  assign MAIN_CLK = st.main_clk;
  assign SYSREF_OUT = st.sysref;
  assign LOGIC_RATE_CLOCK = st.lclk;
  assign LOGIC_SYSREF_OUTPUT = st.lsref;
  assign DELAY_CLK = st.dclk;
  assign MULT_FACTOR = st.mult;
  assign RESET_BUSY = st.busy;

endmodule : cdctl_top

// File: cdctl_pkg.sv
// Shared constants and types for the clock distribution control block.
// Assumes a single 100 MHz system clock and an Avalon-MM register master.
package cdctl_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int POR_TIME_US = 100;
  localparam int POR_CYC = POR_TIME_US * CLK_MHZ;
  localparam int SRST_CYC = 8;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_CHAN = 5'h04;
  localparam logic [4:0] OFF_LGC = 5'h08;
  localparam logic [4:0] OFF_SREF = 5'h0c;
  localparam logic [4:0] OFF_STAT = 5'h10;

  localparam logic [1:0] SRC_BUF = 2'h0;
  localparam logic [1:0] SRC_DIV = 2'h1;
  localparam logic [1:0] SRC_MULT = 2'h2;

  localparam int NCH = 4;
  localparam int TEMP_W = 10;

  typedef struct packed {
    logic [22:0] rsv;
    logic [1:0] mult_code;
    logic div_rst;
    logic [2:0] div_code;
    logic [1:0] src;
    logic srst;
  } cdctl_ctrl_t;

  typedef struct packed {
    logic [11:0] rsv;
    logic [NCH-1:0][2:0] pwr;
    logic [NCH-1:0] buf_en;
    logic [NCH-1:0] path_en;
  } cdctl_chan_t;

  typedef struct packed {
    logic [18:0] rsv;
    logic en;
    logic [9:0] div;
    logic [1:0] pre;
  } cdctl_lgc_t;

  typedef struct packed {
    logic [14:0] rsv;
    logic [1:0] dly_sel;
    logic en;
    logic [11:0] div;
    logic [1:0] pre;
  } cdctl_sref_t;

  typedef struct packed {
    logic [20:0] rsv;
    logic busy;
    logic [TEMP_W-1:0] temp;
  } cdctl_stat_t;

  typedef struct packed {
    cdctl_ctrl_t ctrl;
    cdctl_chan_t chan;
    cdctl_lgc_t lgc;
    cdctl_sref_t sref;
  } cdctl_cfg_t;

  localparam cdctl_ctrl_t CTRL_RST = 32'h0000_0000;
  localparam cdctl_chan_t CHAN_RST = 32'h000f_ffff;
  localparam cdctl_lgc_t LGC_RST = 32'h0000_0004;
  localparam cdctl_sref_t SREF_RST = 32'h0000_0008;
  localparam cdctl_cfg_t CFG_RST = {CTRL_RST, CHAN_RST, LGC_RST, SREF_RST};

  // Per-channel power and level outputs travel together.
  typedef struct packed {
    logic [NCH-1:0] path_up;
    logic [NCH-1:0] buf_up;
    logic [NCH-1:0][2:0] level;
  } cdctl_chan_pwr_t;

endpackage : cdctl_pkg

// File: cdctl_div.sv
// Enable-driven integer divider used for every divide stage of the block.
// Assumes tick is a one-cycle enable on the same clock; ratio 0 acts as 1.
`timescale 1ns/100ps
module cdctl_div #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic clr,
  input wire logic tick,
  input wire logic [W-1:0] ratio,
  // Result
  output logic pulse,
  output logic lvl
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic pulse;
    logic lvl;
  } cdctl_div_st_t;

  cdctl_div_st_t st;
  cdctl_div_st_t next_st;

  // ****************************************************************
  // Counter
  // ****************************************************************
  // High phase lasts ratio/2 rounded down for ratios of two and up, which gives 50% on even ratios
  // and 33/40/43% for 3/5/7; ratio 0 or 1 toggles lvl on every tick.
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (clr) begin
      next_st = '0;
    end else if (tick) begin
      if (ratio <= W'(1)) begin
        next_st.cnt = '0;
        next_st.pulse = 1'b1;
        next_st.lvl = ~st.lvl;
      end else begin
        if (st.cnt >= ratio - W'(1)) begin
          next_st.cnt = '0;
          next_st.pulse = 1'b1;
        end else begin
          next_st.cnt = st.cnt + W'(1);
        end
        next_st.lvl = next_st.cnt < (ratio >> 1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
  assign lvl = st.lvl;

endmodule : cdctl_div

// File: cdctl_properties.sv
// Port checks for the clock distribution control top.
// Assumes one clock domain with active-low reset; bound at the foot.
`timescale 1ns/100ps
module cdctl_properties (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Register bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Status
  input wire cdctl_pkg::cdctl_chan_pwr_t CHAN_PWR,
  input wire logic [2:0] MULT_FACTOR,
  input wire logic RESET_BUSY
);
  import cdctl_pkg::*;
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  sequence s_srst_ack;
    AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFF_CTRL && AVS_WRITEDATA[0];
  endsequence
  // The busy window must be short, or a fast host would stall.
  sequence s_busy_run;
    ##[1:2] RESET_BUSY ##[1:12] !RESET_BUSY;
  endsequence
  property p_srst; s_srst_ack |-> s_busy_run; endproperty
  property p_ack_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  property p_ack_cause; !AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE); endproperty
  property p_busy_hold; RESET_BUSY |-> AVS_WAITREQUEST; endproperty
  property p_rd_idle; AVS_WAITREQUEST |-> AVS_READDATA == 32'h0; endproperty
  property p_path; (CHAN_PWR.buf_up & ~CHAN_PWR.path_up) == 4'h0; endproperty
  property p_level; !CHAN_PWR.buf_up[1] |-> CHAN_PWR.level[1] == 3'h0; endproperty
  property p_mult; MULT_FACTOR inside {[3'h1:3'h4]}; endproperty
  a_srst: assert property (p_srst) else $error("Soft reset window wrong.");
  a_ack_one: assert property (p_ack_one) else $error("Ack too long.");
  a_ack_cause: assert property (p_ack_cause) else $error("Ack without request.");
  a_busy_hold: assert property (p_busy_hold) else $error("Ack while busy.");
  a_rd_idle: assert property (p_rd_idle) else $error("Read data outside answer.");
  a_path: assert property (p_path) else $error("Buffer up with path down.");
  a_level: assert property (p_level) else $error("Level on a dead buffer.");
  a_mult: assert property (p_mult) else $error("Factor out of range.");
endmodule : cdctl_properties

bind cdctl_top cdctl_properties i_props (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CHAN_PWR(CHAN_PWR),
  .MULT_FACTOR(MULT_FACTOR), .RESET_BUSY(RESET_BUSY));

// File: cdctl_host.sv
// Register bus master standing in for the host controller.
// Assumes a slave that drops waitrequest for one cycle per answer.
`timescale 1ns/100ps
module cdctl_host (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [4:0] avs_address = 5'h1f,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines carry the inverse, so a stale value is never trusted.
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : cdctl_host

// File: tb_top.sv
// Self-checking bench for the clock distribution control block.
// Assumes the host model and the bound checker; POR count is shortened.
`timescale 1ns/100ps
module tb_top;
  import cdctl_pkg::*;
  localparam int POR = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] temp = 10'h21a;
  logic [4:0] addr;
  logic rd_s, wr_s, wreq, lclk, lsref, dclk, busy;
  logic [31:0] wdat, rdat;
  logic [3:0] mclk, sg, sref;
  logic [2:0] mult;
  cdctl_chan_pwr_t pwr;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  assign sg = {dclk, lsref, lclk, mclk[0]};
  initial forever #5 clk = ~clk;
  cdctl_host u_host (.clk(clk), .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq));
  cdctl_top #(.POR_CYCLES(POR)) i_dut (.CLK_SYS(clk), .RSTN(rstn), .AVS_ADDRESS(addr),
    .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .TEMP_CODE(temp), .CHAN_PWR(pwr), .MAIN_CLK(mclk),
    .SYSREF_OUT(sref), .LOGIC_RATE_CLOCK(lclk), .LOGIC_SYSREF_OUTPUT(lsref),
    .DELAY_CLK(dclk), .MULT_FACTOR(mult), .RESET_BUSY(busy));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] q;
    u_host.xfer(1'b1, a, v, q);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    u_host.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Period and high time between the second and third rising edges; the
  // first period after a write may still mix the old and the new ratio.
  task automatic chkp(input logic [4:0] a, input logic [31:0] v, input int s, input int n,
                      input int hn);
    int p;
    int h;
    int st;
    logic o;
    wr(a, v);
    p = 0;
    h = 0;
    st = 0;
    o = 1'b1;
    repeat (300) begin
      @(posedge clk);
      if (sg[s] === 1'b1 && o === 1'b0) st++;
      if (st == 2) p++;
      if (st == 2) h += int'(sg[s]);
      if (s == 0) chk(32'(mclk), 32'({4{mclk[0]}}));
      o = sg[s];
    end
    chk(32'(p), 32'(n));
    if (hn >= 0) chk(32'(h), 32'(hn));
  endtask : chkp
  task automatic t_por();
    logic [31:0] d;
    logic [31:0] dv [4];
    int n;
    dv = '{32'h0, 32'h000fffff, 32'h4, 32'h8};
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n <= POR + 2), 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(5'(i * 4), d);
      chk(d, dv[i]);
    end
    chk({12'h0, pwr}, 32'h000fffff);
    chk({28'h0, mult, lclk}, 32'h2);
    $display("t_por done");
  endtask : t_por
  task automatic t_srst();
    logic [31:0] d;
    wr(OFF_CHAN, 32'h0);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_CHAN, d);
    chk(d, 32'h000fffff);
    rd(OFF_CTRL, d);
    chk(d, 32'h1);
    wr(OFF_LGC, 32'h4);
    rd(OFF_CTRL, d);
    chk(d, 32'h0);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_CTRL, d);
    chk(d, 32'h0);
    $display("t_srst done");
  endtask : t_srst
  task automatic t_chan();
    int o;
    int s;
    wr(OFF_CHAN, 32'h0005eb35);
    repeat (3) @(posedge clk);
    chk({12'h0, pwr}, 32'h00051003);
    o = 0;
    repeat (8) begin
      @(posedge clk);
      chk({28'h0, mclk[3:1], 1'b0}, 32'h0);
      o += int'(mclk[0]);
    end
    chk(32'(o), 32'h4);
    wr(OFF_SREF, 32'h4008);
    repeat (3) @(posedge clk);
    s = 0;
    repeat (8) begin
      @(posedge clk);
      chk({28'h0, sref[3], 1'b0, sref[1], 1'b0}, 32'h0);
      s += int'(sref[2]);
    end
    chk(32'(s), 32'h4);
    $display("t_chan done");
  endtask : t_chan
  task automatic t_div();
    logic [3:0] o;
    wr(OFF_CTRL, 32'h1);
    for (int c = 1; c < 8; c++) begin
      wr(OFF_CTRL, 32'h42 | 32'(c << 3));
      repeat (3) @(posedge clk);
      o = mclk;
      repeat (8) @(posedge clk) chk(32'(mclk), 32'(o));
      chkp(OFF_CTRL, 32'h2 | 32'(c << 3), 0, c + 1, (c + 1) / 2);
    end
    $display("t_div done");
  endtask : t_div
  task automatic t_rates();
    chkp(OFF_CTRL, 32'h0, 0, 2, 1);
    for (int m = 0; m < 4; m++) begin
      chkp(OFF_CTRL, 32'h4 | 32'(m << 7), 0, 2, 1);
      chk({29'h0, mult}, 32'(m + 1));
    end
    chkp(OFF_LGC, 32'h100d, 1, 6, -1);
    chkp(OFF_LGC, 32'h1016, 1, 20, -1);
    chkp(OFF_SREF, 32'h400c, 2, 3, -1);
    chkp(OFF_SREF, 32'h4015, 2, 10, -1);
    for (int k = 0; k < 4; k++) chkp(OFF_SREF, 32'(k << 15), 3, 2 << k, 1 << k);
    $display("t_rates done");
  endtask : t_rates
  task automatic t_stat();
    logic [31:0] d;
    rd(OFF_STAT, d);
    chk(d, 32'h21a);
    wr(OFF_STAT, 32'hffffffff);
    temp <= 10'h3c5;
    wr(5'h14, 32'h1);
    rd(5'h14, d);
    chk(d, 32'h0);
    rd(OFF_STAT, d);
    chk(d, 32'h3c5);
    $display("t_stat done");
  endtask : t_stat
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_por();
    t_srst();
    t_chan();
    t_div();
    t_rates();
    t_stat();
    conclude();
  end
  initial begin
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 30000) begin
        fail_count++;
        conclude();
      end
    end
  end
endmodule : tb_top
